// >>> core/hpsc_sync.v
// two-flop synchroniser for signals arriving from outside the clock domain
`timescale 1ns/10ps
module hpsc_sync #(
   parameter WIDTH   = 1,
   parameter RST_VAL = 1'b0
) (
   input  wire             clk_in,
   input  wire             rst_n_in,
   input  wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] meta_q;
   reg [WIDTH-1:0] sync_q;

   // first stage is read by the second stage only
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         meta_q <= {WIDTH{RST_VAL}};
         sync_q <= {WIDTH{RST_VAL}};
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;
endmodule // hpsc_sync

// >>> core/hpsc_top.v
// pin-level strobe and direction control of the 8-bit parallel host port
//
// What this block does
// - enable low, read high: drive data pins
// - enable low, write: data pins stay inputs unless acknowledge is low during a request
// - capture write data at enable rising edge
// - request open-drain in host mode, else push-pull
// - acknowledge completes each requested dma transfer
// - acknowledge with enable high and no request: supply interrupt vector
// - pins are gpio otherwise, inputs after reset
// - data pins released while enable and acknowledge are both high
// - acknowledge during request also drives data pins
// - register select picks accessed register
`timescale 1ns/10ps
`include "hpsc_consts.vh"
module hpsc_top #(
   parameter DATA_W   = `HPSC_DATA_W,
   parameter SEL_W    = `HPSC_SEL_W,
   parameter NUM_REGS = `HPSC_NUM_REGS,
   parameter GPIO_W   = `HPSC_GPIO_W
) (
   input  wire                     clk_in,
   input  wire                     arst_n_in,
   input  wire                     host_mode_in,
   input  wire                     host_enable_strobe_n_in,
   input  wire                     host_read_write_select_in,
   input  wire [SEL_W-1:0]         host_register_select_in,
   input  wire [DATA_W-1:0]        host_data_bus_in,
   output wire [DATA_W-1:0]        host_data_bus_out,
   output wire                     host_data_bus_oe_out,
   input  wire                     host_request_n_in,
   output wire                     host_request_n_out,
   output wire                     host_request_n_oe_out,
   input  wire                     host_acknowledge_n_in,
   output wire                     gpio_line_twelve_out,
   output wire                     gpio_line_twelve_oe_out,
   output wire                     gpio_line_thirteen_out,
   output wire                     gpio_line_thirteen_oe_out,
   output wire                     gpio_line_fourteen_out,
   output wire                     gpio_line_fourteen_oe_out,
   input  wire [GPIO_W-1:0]        gpio_dir_in,
   input  wire [GPIO_W-1:0]        gpio_data_in,
   output wire [GPIO_W-1:0]        gpio_value_out,
   input  wire                     dma_request_in,
   input  wire [NUM_REGS*DATA_W-1:0] read_words_in,
   input  wire [DATA_W-1:0]        vector_in,
   output wire                     write_strobe_out,
   output wire [SEL_W-1:0]         write_select_out,
   output wire [DATA_W-1:0]        write_data_out,
   output wire                     read_done_out,
   output wire                     dma_done_out,
   output wire                     vector_ack_out
);
   //------------------------------------------------------------------
   // reset release
   //------------------------------------------------------------------
   reg rst_meta_q;
   reg rst_n_q;

   always @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rst_meta_q <= 1'b0;
         rst_n_q    <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q    <= rst_meta_q;
      end
   end

   //------------------------------------------------------------------
   // pin synchronisers
   //------------------------------------------------------------------
   wire              en_n_s;
   wire              ack_n_s;
   wire              req_pin_s;
   wire              rw_s;
   wire [SEL_W-1:0]  sel_s;
   wire [DATA_W-1:0] data_s;

   hpsc_sync #(.WIDTH(3), .RST_VAL(1'b1)) u_sync_strobe (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_q),
      .async_in ({host_enable_strobe_n_in, host_acknowledge_n_in, host_request_n_in}),
      .sync_out ({en_n_s, ack_n_s, req_pin_s})
   );

   hpsc_sync #(.WIDTH(1 + SEL_W + DATA_W), .RST_VAL(1'b0)) u_sync_bus (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_q),
      .async_in ({host_read_write_select_in, host_register_select_in, host_data_bus_in}),
      .sync_out ({rw_s, sel_s, data_s})
   );

   //------------------------------------------------------------------
   // strobe edge detection and access capture
   //------------------------------------------------------------------
   reg              en_n_q;
   reg              ack_n_q;
   reg              rw_hold_q;
   reg [SEL_W-1:0]  sel_hold_q;
   reg [DATA_W-1:0] data_hold_q;
   reg              ack_req_q;
   reg              mode_q;
   reg              req_q;

   wire en_rise  = en_n_s & ~en_n_q;
   wire ack_fall = ~ack_n_s & ack_n_q;
   wire ack_rise = ack_n_s & ~ack_n_q;

   always @(posedge clk_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         en_n_q      <= 1'b1;
         ack_n_q     <= 1'b1;
         rw_hold_q   <= 1'b1;
         sel_hold_q  <= {SEL_W{1'b0}};
         data_hold_q <= `HPSC_DATA_RST;
         ack_req_q   <= 1'b0;
         mode_q      <= 1'b0;
         req_q       <= 1'b0;
      end else begin
         en_n_q  <= en_n_s;
         ack_n_q <= ack_n_s;
         mode_q  <= host_mode_in;
         req_q   <= host_mode_in & dma_request_in;
         // keep the last sample seen while enable is low
         if (!en_n_s) begin
            rw_hold_q   <= rw_s;
            sel_hold_q  <= sel_s;
            data_hold_q <= data_s;
         end
         // remember whether the acknowledge arrived during a request
         if (ack_fall) begin
            ack_req_q <= req_q;
         end
      end
   end

   //------------------------------------------------------------------
   // core-side events
   //------------------------------------------------------------------
   reg              wr_stb_q;
   reg [SEL_W-1:0]  wr_sel_q;
   reg [DATA_W-1:0] wr_data_q;
   reg              rd_done_q;
   reg              dma_done_q;
   reg              vec_ack_q;

   always @(posedge clk_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         wr_stb_q   <= 1'b0;
         wr_sel_q   <= {SEL_W{1'b0}};
         wr_data_q  <= `HPSC_DATA_RST;
         rd_done_q  <= 1'b0;
         dma_done_q <= 1'b0;
         vec_ack_q  <= 1'b0;
      end else begin
         wr_stb_q   <= mode_q & en_rise & ~rw_hold_q;
         rd_done_q  <= mode_q & en_rise & rw_hold_q;
         dma_done_q <= mode_q & ack_rise & ack_req_q;
         vec_ack_q  <= mode_q & ack_rise & ~ack_req_q;
         if (mode_q && en_rise && !rw_hold_q) begin
            wr_sel_q  <= sel_hold_q;
            wr_data_q <= data_hold_q;
         end
      end
   end

   //------------------------------------------------------------------
   // data bus direction and read data
   //------------------------------------------------------------------
   reg [DATA_W-1:0] dout_q;
   reg              doe_q;
   reg [DATA_W-1:0] read_word;

   always @* begin
      read_word = read_words_in[sel_s*DATA_W +: DATA_W];
   end

   always @(posedge clk_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         dout_q <= `HPSC_DATA_RST;
         doe_q  <= 1'b0;
      end else begin
         if (!mode_q) begin
            doe_q <= 1'b0;
         end else if (!en_n_s && rw_s) begin
            doe_q  <= 1'b1;
            dout_q <= read_word;
         end else if (!ack_n_s && req_q) begin
            doe_q  <= 1'b1;
            dout_q <= read_word;
         end else if (!ack_n_s && en_n_s) begin
            doe_q  <= 1'b1;
            dout_q <= vector_in;
         end else begin
            doe_q <= 1'b0;
         end
      end
   end

   //------------------------------------------------------------------
   // request pin and gpio fallback
   //------------------------------------------------------------------
   reg [GPIO_W-1:0] gout_q;
   reg [GPIO_W-1:0] goe_q;
   reg [GPIO_W-1:0] gval_q;

   genvar g;
   generate
      for (g = 0; g < GPIO_W; g = g + 1) begin : g_gpio
         always @(posedge clk_in or negedge rst_n_q) begin
            if (!rst_n_q) begin
               gout_q[g] <= 1'b0;
               goe_q[g]  <= 1'b0;
            end else if (mode_q) begin
               gout_q[g] <= 1'b0;
               goe_q[g]  <= (g == `HPSC_GPIO_REQ) ? req_q : 1'b0;
            end else begin
               gout_q[g] <= gpio_data_in[g];
               goe_q[g]  <= gpio_dir_in[g];
            end
         end
      end
   endgenerate

   always @(posedge clk_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         gval_q <= {GPIO_W{1'b1}};
      end else begin
         gval_q <= {ack_n_s, req_pin_s, en_n_s};
      end
   end

   //------------------------------------------------------------------
   // outputs
   //------------------------------------------------------------------
   assign host_data_bus_out         = dout_q;
   assign host_data_bus_oe_out      = doe_q;
   assign host_request_n_out        = gout_q[`HPSC_GPIO_REQ];
   assign host_request_n_oe_out     = goe_q[`HPSC_GPIO_REQ];
   assign gpio_line_twelve_out      = gout_q[`HPSC_GPIO_EN];
   assign gpio_line_twelve_oe_out   = goe_q[`HPSC_GPIO_EN];
   assign gpio_line_thirteen_out    = gout_q[`HPSC_GPIO_REQ];
   assign gpio_line_thirteen_oe_out = goe_q[`HPSC_GPIO_REQ];
   assign gpio_line_fourteen_out    = gout_q[`HPSC_GPIO_ACK];
   assign gpio_line_fourteen_oe_out = goe_q[`HPSC_GPIO_ACK];
   assign gpio_value_out            = gval_q;
   assign write_strobe_out          = wr_stb_q;
   assign write_select_out          = wr_sel_q;
   assign write_data_out            = wr_data_q;
   assign read_done_out             = rd_done_q;
   assign dma_done_out              = dma_done_q;
   assign vector_ack_out            = vec_ack_q;
endmodule // hpsc_top

// >>> include/hpsc_consts.vh
// constants for the host port strobe control block
`ifndef HPSC_CONSTS_VH
`define HPSC_CONSTS_VH
`define HPSC_DATA_W      8
`define HPSC_SEL_W       3
`define HPSC_NUM_REGS    8
`define HPSC_GPIO_W      3
`define HPSC_SYNC_STAGES 2
`define HPSC_GPIO_EN     0
`define HPSC_GPIO_REQ    1
`define HPSC_GPIO_ACK    2
`define HPSC_DATA_RST    8'h00
`define HPSC_VECTOR_RST  8'h0f
`endif

// >>> testbench/hpsc_host_model.sv
// host processor model driving strobes, register select and data
`timescale 1ns/10ps
module hpsc_host_model (
   input  wire        clk_in,
   input  wire  [7:0] pin_in,
   output logic       en_n_out,
   output logic       rw_out,
   output logic [2:0] sel_out,
   output wire  [7:0] data_out,
   output logic       ack_n_out
);
   logic [7:0] d_q = 8'h00;
   logic [7:0] flt_q = 8'h00;
   logic       drv_q = 1'b0;
   // a released bus shows the inverse of its last level
   assign data_out = drv_q ? d_q : flt_q;
   initial begin
      en_n_out = 1'b1;
      rw_out = 1'b1;
      sel_out = 3'h0;
      ack_n_out = 1'b1;
   end
   always @(posedge clk_in) flt_q <= ~pin_in;
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_in);
   endtask
   // q is the bus level just before the strobe rises
   task automatic access(input logic rw, input logic [2:0] sel, input logic [7:0] d,
                         output logic [7:0] q);
      rw_out = rw;
      sel_out = sel;
      d_q = d;
      drv_q = ~rw;
      cyc(1);
      en_n_out = 1'b0;
      cyc(6);
      q = pin_in;
      en_n_out = 1'b1;
      cyc(1);
      drv_q = 1'b0;
      cyc(5);
   endtask
   task automatic ack(output logic [7:0] q);
      ack_n_out = 1'b0;
      cyc(6);
      q = pin_in;
      ack_n_out = 1'b1;
      cyc(6);
   endtask
endmodule // hpsc_host_model

// >>> testbench/hpsc_properties.sv
// assertion checker bound to the host port strobe control top
`timescale 1ns/10ps
module hpsc_properties (
   input wire       clk_in,
   input wire       arst_n_in,
   input wire       host_mode_in,
   input wire       host_enable_strobe_n_in,
   input wire       host_read_write_select_in,
   input wire       host_acknowledge_n_in,
   input wire       dma_request_in,
   input wire [2:0] gpio_dir_in,
   input wire       host_data_bus_oe_out,
   input wire       host_request_n_out,
   input wire       host_request_n_oe_out,
   input wire       gpio_line_twelve_oe_out,
   input wire       gpio_line_thirteen_oe_out,
   input wire       gpio_line_fourteen_oe_out,
   input wire       write_strobe_out,
   input wire       dma_done_out,
   input wire       vector_ack_out
);
   wire       m  = host_mode_in;
   wire       en = host_enable_strobe_n_in;
   wire       ak = host_acknowledge_n_in;
   wire       rw = host_read_write_select_in;
   wire       dq = dma_request_in;
   wire       oe = host_data_bus_oe_out;
   wire       ws = write_strobe_out;
   wire       dd = dma_done_out;
   wire       va = vector_ack_out;
   wire [2:0] go = {gpio_line_fourteen_oe_out, gpio_line_thirteen_oe_out,
                    gpio_line_twelve_oe_out};
   default clocking @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   property p_read; $fell(en) && rw && m && ak |-> ##[2:3] oe; endproperty
   a_read: assert property (p_read) else $error("read not driven");
   property p_wr_in; (!en && !rw && ak)[*5] |-> !oe; endproperty
   a_wr_in: assert property (p_wr_in) else $error("bus driven in write");
   property p_cap; $rose(en) && !rw && m |-> ##[3:4] ws; endproperty
   a_cap: assert property (p_cap) else $error("no write strobe");
   property p_req; m[*3] |-> !host_request_n_out && host_request_n_oe_out == $past(dq, 2);
   endproperty
   a_req: assert property (p_req) else $error("request pin wrong");
   property p_dma; $rose(ak) && dq && m && en |-> ##[3:4] (dd && !va); endproperty
   a_dma: assert property (p_dma) else $error("no dma done");
   property p_vec; $rose(ak) && !dq && m && en |-> ##[3:4] (va && !dd); endproperty
   a_vec: assert property (p_vec) else $error("no vector ack");
   property p_gpio; (!m)[*4] |-> !oe && !ws && go == $past(gpio_dir_in); endproperty
   a_gpio: assert property (p_gpio) else $error("gpio mode wrong");
   property p_rel; (en && ak)[*5] |-> !oe; endproperty
   a_rel: assert property (p_rel) else $error("bus not released");
   property p_ackd; (dq && m && en && !ak)[*5] |-> oe; endproperty
   a_ackd: assert property (p_ackd) else $error("ack not driven");
   property p_sync; ($fell(en) || $fell(ak)) && !oe |=> !oe; endproperty
   a_sync: assert property (p_sync) else $error("strobe not synced");
   c_wr: cover property ($rose(ws));
   c_dd: cover property ($rose(dd));
   c_va: cover property ($rose(va));
endmodule // hpsc_properties

bind hpsc_top hpsc_properties i_props (.*);

// >>> testbench/hpsc_top_test.sv
// self-checking bench for the host port strobe control block
`timescale 1ns/10ps
module hpsc_top_test;
   logic        clk_in = 1'b0;
   logic        arst_n_in = 1'b0;
   logic        mode = 1'b0;
   logic        dma = 1'b0;
   logic [2:0]  dir = 3'h0;
   logic [2:0]  gdat = 3'h0;
   logic [7:0]  q;
   logic [63:0] words = 64'h8877665544332211;
   logic [7:0]  vec = 8'ha5;
   wire  [7:0]  dout, hd, wdat, pin;
   wire  [2:0]  wsel, gval, oeg, outg, h_sel;
   wire         oe, r_out, r_oe, ws, dd, va, rd, h_en, h_ack, h_rw, en_pin, r_pin, a_pin;
   int          errors = 0;
   int          n_tests = 0;
   int          n_wr = 0, n_dd = 0, n_va = 0, n_rd = 0, n_cyc = 0;
   always #5 clk_in = ~clk_in;
   assign pin = oe ? dout : hd;
   // request is open drain with a pull-up
   assign r_pin = r_oe ? r_out : 1'b1;
   assign en_pin = oeg[0] ? outg[0] : h_en;
   assign a_pin = oeg[2] ? outg[2] : h_ack;
   hpsc_host_model i_host (.clk_in(clk_in), .pin_in(pin), .en_n_out(h_en), .rw_out(h_rw),
      .sel_out(h_sel), .data_out(hd), .ack_n_out(h_ack));
   hpsc_top i_dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .host_mode_in(mode),
      .host_enable_strobe_n_in(en_pin), .host_read_write_select_in(h_rw),
      .host_register_select_in(h_sel), .host_data_bus_in(pin), .host_data_bus_out(dout),
      .host_data_bus_oe_out(oe), .host_request_n_in(r_pin), .host_request_n_out(r_out),
      .host_request_n_oe_out(r_oe), .host_acknowledge_n_in(a_pin),
      .gpio_line_twelve_out(outg[0]), .gpio_line_twelve_oe_out(oeg[0]),
      .gpio_line_thirteen_out(outg[1]), .gpio_line_thirteen_oe_out(oeg[1]),
      .gpio_line_fourteen_out(outg[2]), .gpio_line_fourteen_oe_out(oeg[2]),
      .gpio_dir_in(dir), .gpio_data_in(gdat), .gpio_value_out(gval), .dma_request_in(dma),
      .read_words_in(words), .vector_in(vec), .write_strobe_out(ws),
      .write_select_out(wsel), .write_data_out(wdat), .read_done_out(rd),
      .dma_done_out(dd), .vector_ack_out(va));
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
         errors++;
      end
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   always @(posedge clk_in) begin
      if (ws) n_wr <= n_wr + 1;
      if (dd) n_dd <= n_dd + 1;
      if (va) n_va <= n_va + 1;
      if (rd) n_rd <= n_rd + 1;
      n_cyc <= n_cyc + 1;
      if (n_cyc == 2000) begin
         errors++;
         complete_run();
      end
   end
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_gpio;
      check({oe, r_oe, oeg, gval}, 8'h07);
      dir = 3'h7;
      gdat = 3'h2;
      i_host.cyc(6);
      check({oeg, outg, r_out, gval}, {3'h7, 3'h2, 1'b1, 3'h2});
      gdat = 3'h5;
      i_host.cyc(6);
      check({outg, r_pin, gval}, {3'h5, 1'b0, 3'h5});
      dir = 3'h0;
      i_host.access(1'b0, 3'h1, 8'h5a, q);
      check(n_wr, 0);
   endtask
   task automatic t_write;
      for (int i = 0; i < 8; i++) begin
         i_host.access(1'b0, i[2:0], 8'h30 + i[7:0], q);
         check(n_wr, i + 1);
         check({wsel, wdat}, {i[2:0], 8'h30 + i[7:0]});
      end
   endtask
   task automatic t_read;
      for (int i = 0; i < 8; i++) begin
         i_host.access(1'b1, i[2:0], 8'h00, q);
         check(q, 8'h11 * (i + 1));
         check(n_rd, i + 1);
      end
   endtask
   task automatic t_ack;
      dma = 1'b1;
      words[63:56] = 8'h96;
      i_host.cyc(4);
      check({r_oe, r_out, r_pin}, 3'h4);
      i_host.ack(q);
      check(q, 8'h96);
      check(n_dd, 1);
      check(n_va, 0);
      dma = 1'b0;
      vec = 8'h3c;
      i_host.cyc(4);
      check(r_pin, 1);
      i_host.ack(q);
      check(q, 8'h3c);
      check(n_dd, 1);
      check(n_va, 1);
   endtask
   initial begin
      i_host.cyc(10);
      arst_n_in = 1'b1;
      i_host.cyc(4);
      t_gpio();
      mode = 1'b1;
      i_host.cyc(3);
      t_write();
      t_read();
      t_ack();
      complete_run();
   end
endmodule // hpsc_top_test
